// ---- verilog/sel_pkg.sv ----
package sel_pkg;

	// Register bus geometry.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [7:0] OFF_RESULT = 8'hE4;
	localparam logic [7:0] OFF_OUTCTL = 8'hE5;
	localparam logic [7:0] OFF_LATCTL = 8'hE9;
	localparam logic [7:0] OFF_IRQ_STAT = 8'hF0;
	localparam logic [7:0] OFF_IRQ_MASK = 8'hF1;

	// Latch control fields.
	localparam int LC_LINE_EDGE = 1;
	localparam int LC_LINE_EN = 2;
	localparam int LC_LINE_CLR = 3;
	localparam int LC_PWR_EDGE = 4;
	localparam int LC_PWR_EN = 5;
	localparam int LC_PWR_CLR = 6;

	// Result register fields.
	localparam int RES_LEVEL_LSB = 0;
	localparam int RES_LINE_LATCH = 3;
	localparam int RES_FRAME = 4;

	// Outputs control fields.
	localparam int OC_OUT0 = 0;
	localparam int OC_OUT1 = 1;
	localparam int OC_SHIFT = 2;

	// Interrupt status and mask fields.
	localparam int IRQ_LINE = 0;
	localparam int IRQ_PWR = 1;

	// Channel numbering for the latch pair.
	localparam int CH_LINE = 0;
	localparam int CH_PWR = 1;
	localparam int NUM_CH = 2;

	// Reset values of the software-owned fields.
	localparam logic [1:0] EDGE_RST = 2'h0;
	localparam logic [1:0] EN_RST = 2'h0;
	localparam logic [2:0] OUTCTL_RST = 3'h4;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// Comparator thresholds in millivolts.
	localparam int LEVEL_W = 3;
	localparam int MV_W = 13;
	localparam int NUM_THR = 5;
	localparam logic [12:0] THR_LOW_MV = 13'h3E8;
	localparam logic [12:0] THR_STEP_MV = 13'h3E8;
	localparam logic [12:0] SHIFT_MV = 13'h1F4;
	localparam logic [2:0] LEVEL_MAX = 3'h5;

endpackage

// ---- verilog/sel_latch_if.sv ----
`timescale 1ns/10ps
interface sel_latch_if;
	logic pin;
	logic edge_rise;
	logic clear;
	logic enable;
	logic latched;
	logic set_pulse;
	logic req_n;

	modport latch (
		input pin,
		input edge_rise,
		input clear,
		input enable,
		output latched,
		output set_pulse,
		output req_n
	);

	modport ctrl (
		output pin,
		output edge_rise,
		output clear,
		output enable,
		input latched,
		input set_pulse,
		input req_n
	);
endinterface

// ---- verilog/sel_edge_latch.sv ----
`timescale 1ns/10ps
module sel_edge_latch
	import sel_pkg::*;
(
	// Clock and reset.
	input logic clk,
	input logic rst,
	// Channel carrier.
	sel_latch_if.latch lif
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic primed;
		logic latched;
	} sel_latch_s;

	sel_latch_s q;
	sel_latch_s d;
	logic rise;
	logic fall;
	logic hit;

	// primed masks only the first cycle after reset; prev still holds a reset zero
	// after that, so a pin already high at reset release fakes a rising edge.
	assign rise = q.primed & q.sync2 & ~q.prev;
	assign fall = q.primed & ~q.sync2 & q.prev;
	assign hit = lif.edge_rise ? rise : fall; // [R1] [R6]

	always_comb begin
		d = q;
		d.sync1 = lif.pin; // [R16]
		d.sync2 = q.sync1;
		d.prev = q.sync2;
		d.primed = 1'b1;
		if (lif.clear) begin
			d.latched = 1'b0; // [R2] [R7]
		end
		if (hit) begin
			d.latched = 1'b1; // [R16]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign lif.latched = q.latched;
	assign lif.set_pulse = hit;
	assign lif.req_n = ~(lif.enable & q.latched); // [R3] [R4] [R8]

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence sel_rise_s;
		lif.edge_rise && q.primed && q.sync2 && !q.prev;
	endsequence

	sequence sel_fall_s;
		!lif.edge_rise && q.primed && !q.sync2 && q.prev;
	endsequence

	edge_rise_set_a: assert property (sel_rise_s |=> q.latched) // [R1]
		else $error("selected rising edge did not set the latch");
	edge_fall_set_a: assert property (sel_fall_s |=> q.latched) // [R6]
		else $error("selected falling edge did not set the latch");
	latch_hold_a: assert property (q.latched && !lif.clear |=> q.latched) // [R16]
		else $error("latch dropped without a clear");
	wrong_edge_a: assert property ( // [R1]
		!q.latched && lif.edge_rise && q.primed
		&& !q.sync2 && q.prev |=> !q.latched)
		else $error("latch set on the unselected edge");

endmodule

// ---- verilog/sel_top.sv ----
`timescale 1ns/10ps
// Operation
// R1 - Line latch sets on rising edge if line edge select is one, else falling.
// R2 - Writing one to latch control bit 3 clears the line latch, every time. Here a selected line edge in the same cycle wins and sets it.
// R3 - Line enable one drives line request low while line latch is set.
// R4 - Line enable zero holds the line request high.
// R5 - Result register bit 3 reads one while the line latch is set.
// R6 - Power latch sets on rising edge if power edge select is one, else falling.
// R7 - Writing one to latch control bit 6 clears the power latch, every time. Here a selected power edge in the same cycle wins and sets it.
// R8 - Power enable gates inverted power latch onto request; otherwise high.
// R9 - Result frame bit reads the inverse of the live frame-sync pin.
// R10 - Result low three bits follow the comparator's present level continuously.
// R11 - Level index is binary: 000 below lowest threshold, 101 above highest.
// R12 - Range shift zero selects 0.5V to 4.5V, one selects 1.0V to 5.0V.
// R13 - Range shift lives in bit 2 of the outputs control register.
// R14 - Two outputs control bits drive the two general output pins.
// R15 - Latch control bits 0 and 7 do nothing.
// R16 - Latches hold until cleared; pins are synchronised before edge detect.
// R17 - Software sets edges, then clears latches, before enabling.
module sel_top
	import sel_pkg::*;
(
	// Clock and reset.
	input logic clk,
	input logic rst,
	// Register port.
	input logic [ADDR_W-1:0] addr,
	input logic [DATA_W-1:0] wdata,
	input logic wr,
	input logic rd,
	output logic [DATA_W-1:0] rdata,
	// Sync and comparator inputs.
	input logic line_sync_port_pin,
	input logic power_port_pin,
	input logic frame_sync_pin,
	input logic [MV_W-1:0] level_mv,
	// Core requests and pins.
	output logic line_request_n,
	output logic power_request_n,
	output logic general_out_0,
	output logic general_out_1,
	output logic irq
);

	typedef struct packed {
		logic [NUM_CH-1:0] edge_sel;
		logic [NUM_CH-1:0] irq_en;
		logic [2:0] outctl;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [LEVEL_W-1:0] level;
		logic [DATA_W-1:0] rdata;
	} sel_state_s;

	sel_state_s q;
	sel_state_s d;

	logic [NUM_CH-1:0] pin_v;
	logic [NUM_CH-1:0] clr_v;
	logic [NUM_CH-1:0] latched_v;
	logic [NUM_CH-1:0] set_v;
	logic [NUM_CH-1:0] req_n_v;
	logic [NUM_THR-1:0] above;
	logic wr_latctl;
	logic rd_result;

	sel_latch_if lif [NUM_CH] ();

	assign wr_latctl = wr && (addr == OFF_LATCTL);
	assign rd_result = rd && (addr == OFF_RESULT);

	// Clear strobes act only on the write cycle; the bits are never stored.
	assign clr_v[CH_LINE] = wr_latctl && wdata[LC_LINE_CLR]; // [R2]
	assign clr_v[CH_PWR] = wr_latctl && wdata[LC_PWR_CLR]; // [R7]
	assign pin_v[CH_LINE] = line_sync_port_pin;
	assign pin_v[CH_PWR] = power_port_pin;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			assign lif[g].pin = pin_v[g];
			assign lif[g].edge_rise = q.edge_sel[g];
			assign lif[g].clear = clr_v[g];
			assign lif[g].enable = q.irq_en[g];
			assign latched_v[g] = lif[g].latched;
			assign set_v[g] = lif[g].set_pulse;
			assign req_n_v[g] = lif[g].req_n;
			sel_edge_latch u_latch (
				.clk(clk),
				.rst(rst),
				.lif(lif[g])
			);
		end
		// Thresholds rise in fixed steps; a clear shift bit lowers all of them.
		for (g = 0; g < NUM_THR; g++) begin : g_thr
			localparam logic [12:0] THR =
				13'(THR_LOW_MV + g * THR_STEP_MV);
			assign above[g] = q.outctl[OC_SHIFT] ?
				(level_mv > THR) : (level_mv > THR - SHIFT_MV); // [R12]
		end
	endgenerate

	always_comb begin
		logic [LEVEL_W-1:0] cnt;
		cnt = '0;
		d = q;
		// Monotone thresholds, so the count of those passed is the index.
		for (int j = 0; j < NUM_THR; j++) begin
			cnt = cnt + LEVEL_W'(above[j]); // [R11]
		end
		d.level = cnt; // [R10]
		if (wr) begin
			unique case (addr)
				OFF_LATCTL: begin
					// Bits 0 and 7 are simply not decoded.
					d.edge_sel[CH_LINE] = wdata[LC_LINE_EDGE]; // [R1] [R15]
					d.edge_sel[CH_PWR] = wdata[LC_PWR_EDGE]; // [R6]
					d.irq_en[CH_LINE] = wdata[LC_LINE_EN]; // [R3]
					d.irq_en[CH_PWR] = wdata[LC_PWR_EN]; // [R8]
				end
				OFF_OUTCTL: begin
					d.outctl = wdata[2:0]; // [R13] [R14]
				end
				OFF_IRQ_STAT: begin
					d.irq_stat = q.irq_stat & ~wdata[1:0];
				end
				OFF_IRQ_MASK: begin
					d.irq_mask = wdata[1:0];
				end
				default: begin
				end
			endcase
		end
		// A latch event in the clearing cycle still lands.
		d.irq_stat[IRQ_LINE] = d.irq_stat[IRQ_LINE] | set_v[CH_LINE];
		d.irq_stat[IRQ_PWR] = d.irq_stat[IRQ_PWR] | set_v[CH_PWR];
		d.rdata = '0;
		if (rd) begin
			unique case (addr)
				OFF_RESULT: begin
					d.rdata[RES_LEVEL_LSB +: LEVEL_W] = q.level; // [R10]
					d.rdata[RES_LINE_LATCH] = latched_v[CH_LINE]; // [R5]
					d.rdata[RES_FRAME] = ~frame_sync_pin; // [R9]
				end
				OFF_LATCTL: begin
					d.rdata[LC_LINE_EDGE] = q.edge_sel[CH_LINE];
					d.rdata[LC_LINE_EN] = q.irq_en[CH_LINE];
					d.rdata[LC_PWR_EDGE] = q.edge_sel[CH_PWR];
					d.rdata[LC_PWR_EN] = q.irq_en[CH_PWR];
				end
				OFF_OUTCTL: begin
					d.rdata[2:0] = q.outctl;
				end
				OFF_IRQ_STAT: begin
					d.rdata[1:0] = q.irq_stat;
				end
				OFF_IRQ_MASK: begin
					d.rdata[1:0] = q.irq_mask;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q.edge_sel <= EDGE_RST;
			q.irq_en <= EN_RST;
			q.outctl <= OUTCTL_RST;
			q.irq_stat <= IRQ_RST;
			q.irq_mask <= IRQ_RST;
			q.level <= '0;
			q.rdata <= '0;
		end else begin
			q <= d;
		end
	end

	assign rdata = q.rdata;
	assign line_request_n = req_n_v[CH_LINE]; // [R3] [R4]
	assign power_request_n = req_n_v[CH_PWR]; // [R8]
	assign general_out_0 = q.outctl[OC_OUT0]; // [R14]
	assign general_out_1 = q.outctl[OC_OUT1]; // [R14]
	assign irq = |(q.irq_stat & q.irq_mask);

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence line_clr_s;
		wr_latctl && wdata[LC_LINE_CLR] && !set_v[CH_LINE];
	endsequence

	sequence pwr_clr_s;
		wr_latctl && wdata[LC_PWR_CLR] && !set_v[CH_PWR];
	endsequence

	sequence spare_bits_s;
		wr_latctl && ((wdata & 8'h48) == 8'h00);
	endsequence

	sequence level_top_s;
		level_mv > 13'h1388 && q.outctl[OC_SHIFT];
	endsequence

	line_clear_a: assert property (line_clr_s |=> !latched_v[CH_LINE]) // [R2]
		else $error("line latch not cleared by write of one");
	power_clear_a: assert property (pwr_clr_s |=> !latched_v[CH_PWR]) // [R7]
		else $error("power latch not cleared by write of one");
	spare_bits_a: assert property ( // [R15]
		spare_bits_s ##0 latched_v == 2'h3 |=> latched_v == 2'h3)
		else $error("write without clear bits disturbed a latch");
	line_request_a: assert property ( // [R3]
		q.irq_en[CH_LINE] && latched_v[CH_LINE] |-> !line_request_n)
		else $error("enabled line latch gave no request");
	line_gated_a: assert property ( // [R4]
		wr_latctl && !wdata[LC_LINE_EN] |=> line_request_n)
		else $error("disabled line request not held high");
	power_request_a: assert property ( // [R8]
		power_request_n == !(q.irq_en[CH_PWR] && latched_v[CH_PWR]))
		else $error("power request does not follow latch and enable");
	result_latch_a: assert property ( // [R5]
		rd_result |=> rdata[RES_LINE_LATCH] == $past(latched_v[CH_LINE]))
		else $error("result bit 3 does not show the line latch");
	frame_read_a: assert property ( // [R9]
		rd_result |=> rdata[RES_FRAME] == !$past(frame_sync_pin))
		else $error("frame bit is not the inverted pin");
	level_range_a: assert property (q.level <= LEVEL_MAX) // [R11]
		else $error("level index beyond top code");
	level_top_a: assert property ( // [R12]
		level_top_s ##1 level_top_s |-> q.level == LEVEL_MAX)
		else $error("level above top threshold not coded 101");
	level_floor_a: assert property ( // [R10]
		level_mv < 13'h1F4 ##1 level_mv < 13'h1F4 |-> q.level == 3'h0)
		else $error("level below lowest threshold not zero");
	out_pins_a: assert property ( // [R14]
		wr && addr == OFF_OUTCTL |=> general_out_0 == $past(wdata[0])
		&& general_out_1 == $past(wdata[1]))
		else $error("general outputs do not follow the write");
	irq_status_a: assert property ( // [R16]
		set_v[CH_LINE] |=> q.irq_stat[IRQ_LINE])
		else $error("line event lost from status");

endmodule

// ---- dv/sel_src_model.sv ----
`timescale 1ns/10ps
// Drives the sync, power-key and analogue inputs. Each change is held for
// four cycles, so the two-flop synchroniser and edge detector always see it.
module sel_src_model
	import sel_pkg::*;
(
	// Clock.
	input logic clk,
	// Driven pins.
	output logic line_sync_port_pin,
	output logic power_port_pin,
	output logic frame_sync_pin,
	output logic [MV_W-1:0] level_mv
);
	initial begin
		line_sync_port_pin = 1'h0;
		power_port_pin = 1'h0;
		frame_sync_pin = 1'h0;
		level_mv = 13'h0000;
	end

	task automatic put(input int sel, input logic [MV_W-1:0] v);
		@(posedge clk);
		case (sel)
			0: line_sync_port_pin <= v[0];
			1: power_port_pin <= v[0];
			2: frame_sync_pin <= v[0];
			default: level_mv <= v;
		endcase
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
module testbench
	import sel_pkg::*;
;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [DATA_W-1:0] wdata = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [DATA_W-1:0] rdata;
	logic line_pin, pwr_pin, frame_pin;
	logic [MV_W-1:0] level_mv;
	logic line_req_n, pwr_req_n, out0, out1, irq;
	int failures = 0;
	int n_compared = 0;
	// Level table: range shift, input millivolts, expected level index.
	localparam logic [7:0] SH = 8'h1F;
	localparam logic [12:0] MV [8] = '{13'h0000, 13'h03E8, 13'h03E9,
		13'h09C4, 13'h1389, 13'h01F4, 13'h01F5, 13'h1195};
	localparam logic [2:0] LV [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h5,
		3'h0, 3'h1, 3'h5};

	always #5 clk = ~clk;

	sel_top sel_top_i (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .line_sync_port_pin(line_pin),
		.power_port_pin(pwr_pin), .frame_sync_pin(frame_pin),
		.level_mv(level_mv), .line_request_n(line_req_n),
		.power_request_n(pwr_req_n), .general_out_0(out0),
		.general_out_1(out1), .irq(irq)
	);

	sel_src_model sel_src_model_i (
		.clk(clk), .line_sync_port_pin(line_pin),
		.power_port_pin(pwr_pin), .frame_sync_pin(frame_pin),
		.level_mv(level_mv)
	);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// Ends at a falling edge so that callers sample settled outputs.
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		@(negedge clk);
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		@(negedge clk);
		chk(rdata, e);
	endtask

	task automatic pn(input int s, input logic [12:0] v);
		sel_src_model_i.put(s, v);
	endtask

	task automatic t_reset();
		chk({6'h00, pwr_req_n, line_req_n}, 8'h03);
		chk({6'h00, out1, out0}, 8'h00);
		reg_rd(OFF_LATCTL, 8'h00);
		reg_rd(OFF_OUTCTL, 8'h04);
		reg_rd(OFF_IRQ_STAT, 8'h00);
		reg_rd(OFF_IRQ_MASK, 8'h00);
		reg_rd(8'h20, 8'h00);
		$display("reset test done");
	endtask

	task automatic t_line();
		reg_wr(OFF_LATCTL, 8'h4A);
		reg_wr(OFF_LATCTL, 8'h06);
		pn(0, 13'h1);
		chk({7'h0, line_req_n}, 8'h00);
		reg_rd(OFF_RESULT, 8'h18);
		reg_wr(OFF_LATCTL, 8'h0E);
		reg_rd(OFF_RESULT, 8'h10);
		pn(0, 13'h0);
		reg_rd(OFF_RESULT, 8'h10);
		reg_wr(OFF_LATCTL, 8'h04);
		pn(0, 13'h1);
		chk({7'h0, line_req_n}, 8'h01);
		pn(0, 13'h0);
		chk({7'h0, line_req_n}, 8'h00);
		reg_wr(OFF_LATCTL, 8'h00);
		chk({7'h0, line_req_n}, 8'h01);
		reg_rd(OFF_RESULT, 8'h18);
		reg_wr(OFF_LATCTL, 8'h08);
		reg_rd(OFF_RESULT, 8'h10);
		$display("line latch test done");
	endtask

	task automatic t_pwr();
		reg_wr(OFF_LATCTL, 8'h70);
		pn(1, 13'h1);
		chk({7'h0, pwr_req_n}, 8'h00);
		reg_rd(OFF_LATCTL, 8'h30);
		reg_wr(OFF_LATCTL, 8'h10);
		chk({7'h0, pwr_req_n}, 8'h01);
		// Clear and enable together: a missed clear shows as a low request.
		reg_wr(OFF_LATCTL, 8'h60);
		chk({7'h0, pwr_req_n}, 8'h01);
		pn(1, 13'h0);
		chk({7'h0, pwr_req_n}, 8'h00);
		// Enable stays on, so only a working clear brings the request high.
		reg_wr(OFF_LATCTL, 8'h60);
		chk({7'h0, pwr_req_n}, 8'h01);
		$display("power latch test done");
	endtask

	task automatic t_bits();
		reg_wr(OFF_LATCTL, 8'h00);
		pn(0, 13'h1);
		pn(0, 13'h0);
		reg_wr(OFF_LATCTL, 8'h85);
		chk({7'h0, line_req_n}, 8'h00);
		reg_rd(OFF_LATCTL, 8'h04);
		reg_wr(OFF_LATCTL, 8'h08);
		$display("unused bits test done");
	endtask

	task automatic t_frame();
		pn(2, 13'h1);
		reg_rd(OFF_RESULT, 8'h00);
		pn(2, 13'h0);
		reg_rd(OFF_RESULT, 8'h10);
		$display("frame test done");
	endtask

	task automatic t_level();
		for (int i = 0; i < 8; i++) begin
			reg_wr(OFF_OUTCTL, {5'h00, SH[i], 2'h0});
			pn(3, MV[i]);
			reg_rd(OFF_RESULT, {5'h02, LV[i]});
		end
		$display("level test done");
	endtask

	task automatic t_out();
		for (int v = 0; v < 4; v++) begin
			reg_wr(OFF_OUTCTL, 8'h04 | 8'(v));
			chk({6'h00, out1, out0}, 8'(v));
			reg_rd(OFF_OUTCTL, 8'h04 | 8'(v));
		end
		$display("outputs test done");
	endtask

	task automatic t_irq();
		reg_wr(OFF_IRQ_STAT, 8'h03);
		reg_rd(OFF_IRQ_STAT, 8'h00);
		reg_wr(OFF_IRQ_MASK, 8'h02);
		reg_wr(OFF_LATCTL, 8'h12);
		pn(0, 13'h1);
		chk({7'h0, irq}, 8'h00);
		reg_rd(OFF_IRQ_STAT, 8'h01);
		pn(1, 13'h1);
		chk({7'h0, irq}, 8'h01);
		reg_wr(OFF_IRQ_STAT, 8'h02);
		chk({7'h0, irq}, 8'h00);
		reg_rd(OFF_IRQ_STAT, 8'h01);
		reg_wr(OFF_IRQ_MASK, 8'h03);
		chk({7'h0, irq}, 8'h01);
		reg_wr(OFF_IRQ_STAT, 8'h01);
		chk({7'h0, irq}, 8'h00);
		// Both latches are still set; spare bits must leave them alone.
		reg_wr(OFF_LATCTL, 8'hB7);
		chk({6'h00, pwr_req_n, line_req_n}, 8'h00);
		$display("interrupt test done");
	endtask

	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_line();
		t_pwr();
		t_bits();
		t_frame();
		t_level();
		t_out();
		t_irq();
		wrap_up();
	end

	// The tests need about 240 cycles; allow some thirty times that.
	initial begin
		#80000;
		failures++;
		wrap_up();
	end
endmodule
